// [verilog/scss_params.svh]
// Constants for the system clock source select block
`ifndef SCSS_PARAMS_SVH
`define SCSS_PARAMS_SVH

// Nominal source frequencies in kHz
`define SCSS_HF_FREQ_KHZ 16000
`define SCSS_MF_FREQ_KHZ 500
`define SCSS_LF_FREQ_KHZ 31
`define SCSS_SYS_FREQ_KHZ 125000
// Multiplier from the mid source up to the high source
`define SCSS_MULT_FACTOR (`SCSS_HF_FREQ_KHZ / `SCSS_MF_FREQ_KHZ)
// Half periods of the sources in system clock cycles
`define SCSS_MF_HALF_CYC ((`SCSS_SYS_FREQ_KHZ / `SCSS_MF_FREQ_KHZ) / 2)
`define SCSS_LF_HALF_CYC ((`SCSS_SYS_FREQ_KHZ / `SCSS_LF_FREQ_KHZ) / 2)
// Tuning field width and neutral value
`define SCSS_TUNE_W 6
`define SCSS_TUNE_RST 6'h00
// Clock output divides the selected clock by this
`define SCSS_CLKOUT_DIV 4
// Runtime select field encodings
`define SCSS_SCS_CFG 2'h0
`define SCSS_SCS_EXT 2'h1
// Config source field encodings
`define SCSS_FOSC_EXTERNAL_RC_MODE 3'h3
`define SCSS_FOSC_INTERNAL_OSCILLATOR_MODE 3'h4
`define SCSS_FOSC_EXT 3'h0
// Internal frequency select encodings
`define SCSS_IRCF_HF 2'h2
`define SCSS_IRCF_MF 2'h1
`define SCSS_IRCF_LF 2'h0
`define SCSS_CNT_W 16

`endif

// [verilog/scss_pkg.sv]
// Types for the system clock source select block
package scss_pkg;
	typedef enum logic [1:0] {
		SCSS_SRC_LF = 2'h0,
		SCSS_SRC_MF = 2'h1,
		SCSS_SRC_HF = 2'h2,
		SCSS_SRC_EXT = 2'h3
	} scss_src_t;
	typedef enum logic [1:0] {
		SCSS_SW_RUN = 2'h0,
		SCSS_SW_OLD_LOW = 2'h1,
		SCSS_SW_NEW_LOW = 2'h2
	} scss_sw_t;
endpackage

// [verilog/scss_osc.sv]
// Tunable square wave source made from the system clock
`timescale 1ns/10ps
`default_nettype none
`include "scss_params.svh"
module scss_osc #(
	parameter logic [15:0] HALF_CYC = 16'h0001,
	parameter bit TUNABLE = 1'b1
) (
	input wire logic clk_in, // System clock
	input wire logic rstn_in, // Async reset, low
	input wire logic signed [5:0] tune_in, // Signed trim
	output logic osc_out // Source clock level
);
	logic [15:0] cnt_r;
	logic [15:0] lim;
	logic osc_r;
	wire logic [15:0] trim = TUNABLE ? {{10{tune_in[5]}}, tune_in} : 16'h0000;
	// Trim moves the half period, never below two cycles
	assign lim = ((HALF_CYC - trim) < 16'h0002) ? 16'h0002 : (HALF_CYC - trim);
	assign osc_out = osc_r;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_r <= 16'h0000;
			osc_r <= 1'b0;
		end else if (cnt_r >= lim - 16'h0001) begin
			cnt_r <= 16'h0000;
			osc_r <= ~osc_r;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// [verilog/scss_mult.sv]
// Frequency multiplying loop locked to the mid source
`timescale 1ns/10ps
`default_nettype none
`include "scss_params.svh"
module scss_mult (
	input wire logic clk_in, // System clock
	input wire logic rstn_in, // Async reset, low
	input wire logic ref_in, // Mid source level
	output logic mult_out // Multiplied clock level
);
	// Measures the reference period and toggles 2*factor times per period
	// Fractional accumulator keeps the average rate exact; edges jitter by one cycle
	logic ref_d_r;
	logic [15:0] per_cnt_r;
	logic [15:0] per_r;
	logic [15:0] acc_r;
	logic mult_r;
	wire logic ref_rise = ref_in & ~ref_d_r;
	wire logic [15:0] inc = 16'(2 * `SCSS_MULT_FACTOR);
	wire logic [15:0] acc_sum = acc_r + inc;
	wire logic wrap = (per_r != 16'h0000) & (acc_sum >= per_r);
	assign mult_out = mult_r;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ref_d_r <= 1'b0;
			per_cnt_r <= 16'h0000;
			per_r <= 16'h0000;
			acc_r <= 16'h0000;
			mult_r <= 1'b0;
		end else begin
			ref_d_r <= ref_in;
			per_cnt_r <= ref_rise ? 16'h0001 : per_cnt_r + 16'h0001;
			if (ref_rise)
				per_r <= per_cnt_r;
			if (per_r == 16'h0000)
				acc_r <= 16'h0000;
			else if (wrap)
				acc_r <= acc_sum - per_r;
			else
				acc_r <= acc_sum;
			if (wrap)
				mult_r <= ~mult_r;
		end
	end
endmodule
`default_nettype wire

// [verilog/scss_top.sv]
// System clock source selection, clock output and pin release
`timescale 1ns/10ps
`default_nettype none
`include "scss_params.svh"
// Function
// - Two independent oscillators and one multiplying loop feed three internal clock sources.
// - The high source is calibrated and runs at 16 MHz nominal.
// - The high source comes from the mid source through the multiplying loop.
// - The mid source is calibrated and runs at 500 kHz nominal.
// - The low source runs at 31 kHz nominal with no calibration.
// - A software tuning value trims the high and mid sources but not the low one.
// - After reset the clock comes from the three-bit configuration source field.
// - Writing the two-bit runtime select field switches the clock source while running.
// - In internal oscillator mode the input pin is released for general I/O.
// - The output pin is general I/O or a quarter-rate clock as the enable bit selects.
// - In external RC mode only the input pin carries the timing network.
module scss_top (
	input wire logic SYS_CLK_IN, // 125 MHz clock
	input wire logic RSTN_IN, // Async reset, low
	input wire logic [2:0] FOSC_CFG_IN, // Config source field
	input wire logic CLKOUT_EN_IN, // Config clock output enable
	input wire logic [1:0] SCS_IN, // Runtime select field
	input wire logic [1:0] IRCF_IN, // Internal frequency pick
	input wire logic [5:0] TUNE_IN, // Tuning register value
	input wire logic EXT_CLK_IN, // Input pin level
	input wire logic GPIO_OSC2_OUT_IN, // I/O data for output pin
	input wire logic GPIO_OSC2_OE_IN, // I/O enable for output pin
	output logic SYS_CLK_SEL_OUT, // Selected system clock
	output scss_pkg::scss_src_t SRC_OUT, // Active source
	output logic SWITCHING_OUT, // Switch in progress
	output logic OSC1_GPIO_OUT, // Input pin free for I/O
	output logic OSC2_OUT, // Output pin level
	output logic OSC2_OE_OUT // Output pin drive
);
	import scss_pkg::*;

	// ****************************************
	// Sources
	// ****************************************
	logic mf_clk;
	logic hf_clk;
	logic lf_clk;
	logic ext_s1_r;
	logic ext_s2_r;
	logic [5:0] tune_s1_r;
	logic [5:0] tune_r;
	logic [1:0] scs_s1_r;
	logic [1:0] scs_r;

	// Mid source, trimmed by the tuning value
	scss_osc #(.HALF_CYC(16'(`SCSS_MF_HALF_CYC)), .TUNABLE(1'b1)) u_mf (
		.clk_in(SYS_CLK_IN),
		.rstn_in(RSTN_IN),
		.tune_in(tune_r),
		.osc_out(mf_clk)
	);
	// Low source has no trim path
	scss_osc #(.HALF_CYC(16'(`SCSS_LF_HALF_CYC)), .TUNABLE(1'b0)) u_lf (
		.clk_in(SYS_CLK_IN),
		.rstn_in(RSTN_IN),
		.tune_in(6'h00),
		.osc_out(lf_clk)
	);
	// High source follows the mid source trim through the loop
	scss_mult u_mult (
		.clk_in(SYS_CLK_IN),
		.rstn_in(RSTN_IN),
		.ref_in(mf_clk),
		.mult_out(hf_clk)
	);

	// Pin and software inputs cross into this domain
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			tune_s1_r <= `SCSS_TUNE_RST;
			tune_r <= `SCSS_TUNE_RST;
			scs_s1_r <= `SCSS_SCS_CFG;
			scs_r <= `SCSS_SCS_CFG;
		end else begin
			ext_s1_r <= EXT_CLK_IN;
			ext_s2_r <= ext_s1_r;
			tune_s1_r <= TUNE_IN;
			tune_r <= tune_s1_r;
			scs_s1_r <= SCS_IN;
			scs_r <= scs_s1_r;
		end
	end

	// ****************************************
	// Source decode
	// ****************************************
	logic [2:0] fosc_r;
	logic cfg_taken_r;
	// Holds switching off until the synchronised selects are valid
	logic settle_r;
	logic [1:0] ircf_s1_r;
	logic [1:0] ircf_r;

	// Config field is caught after reset release, not under reset
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			fosc_r <= `SCSS_FOSC_EXT;
			cfg_taken_r <= 1'b0;
			settle_r <= 1'b0;
			ircf_s1_r <= `SCSS_IRCF_LF;
			ircf_r <= `SCSS_IRCF_LF;
		end else begin
			settle_r <= cfg_taken_r;
			ircf_s1_r <= IRCF_IN;
			ircf_r <= ircf_s1_r;
			if (!cfg_taken_r) begin
				fosc_r <= FOSC_CFG_IN;
				cfg_taken_r <= 1'b1;
			end
		end
	end

	wire logic cfg_is_int = (fosc_r == `SCSS_FOSC_INTERNAL_OSCILLATOR_MODE);
	wire logic cfg_is_rc = (fosc_r == `SCSS_FOSC_EXTERNAL_RC_MODE);
	wire logic use_int = scs_r[1] | ((scs_r == `SCSS_SCS_CFG) & cfg_is_int);
	wire scss_src_t int_src = (ircf_r == `SCSS_IRCF_HF) ? SCSS_SRC_HF :
		(ircf_r == `SCSS_IRCF_MF) ? SCSS_SRC_MF : SCSS_SRC_LF;
	wire scss_src_t want_src = use_int ? int_src : SCSS_SRC_EXT;

	function automatic logic src_lvl(input scss_src_t s, input logic lf, input logic mf,
		input logic hf, input logic ex);
		case (s)
			SCSS_SRC_LF: src_lvl = lf;
			SCSS_SRC_MF: src_lvl = mf;
			SCSS_SRC_HF: src_lvl = hf;
			default: src_lvl = ex;
		endcase
	endfunction

	// ****************************************
	// Glitch free switch
	// ****************************************
	scss_src_t cur_r;
	scss_src_t nxt_r;
	scss_sw_t sw_r;
	scss_sw_t sw_nxt;
	logic switching_r;
	logic sys_r;
	logic gate_r;

	wire logic cur_lvl = src_lvl(cur_r, lf_clk, mf_clk, hf_clk, ext_s2_r);
	wire logic new_lvl = src_lvl(nxt_r, lf_clk, mf_clk, hf_clk, ext_s2_r);

	// Output is held low from the switch start until the new low; costs up to a half period of the old and of the new source
	always_comb begin
		sw_nxt = sw_r;
		case (sw_r)
			// A reset-value select would start a false switch before the syncs fill
			SCSS_SW_RUN: if (settle_r && want_src != cur_r) sw_nxt = SCSS_SW_OLD_LOW;
			SCSS_SW_OLD_LOW: if (!cur_lvl) sw_nxt = SCSS_SW_NEW_LOW;
			SCSS_SW_NEW_LOW: if (!new_lvl) sw_nxt = SCSS_SW_RUN;
			default: sw_nxt = SCSS_SW_RUN;
		endcase
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			cur_r <= SCSS_SRC_EXT;
			nxt_r <= SCSS_SRC_EXT;
			sw_r <= SCSS_SW_RUN;
			switching_r <= 1'b0;
			gate_r <= 1'b0;
		end else begin
			sw_r <= sw_nxt;
			switching_r <= (sw_nxt != SCSS_SW_RUN);
			if (sw_r == SCSS_SW_RUN && sw_nxt == SCSS_SW_OLD_LOW)
				nxt_r <= want_src;
			if (sw_r == SCSS_SW_NEW_LOW && sw_nxt == SCSS_SW_RUN)
				cur_r <= nxt_r;
			gate_r <= cfg_taken_r & (sw_nxt != SCSS_SW_NEW_LOW);
		end
	end

	wire logic sys_nxt = gate_r & (sw_r != SCSS_SW_NEW_LOW) & cur_lvl & (sw_r == SCSS_SW_RUN);

	// ****************************************
	// Clock output divider and pins
	// ****************************************
	logic sys_d_r;
	logic [1:0] div_r;
	logic osc2_r;
	logic osc2_oe_r;
	logic osc1_gpio_r;
	wire logic sys_rise = sys_r & ~sys_d_r;
	// Quarter rate: toggle every second rising edge of the selected clock
	wire logic div_tog = sys_rise & (div_r == 2'(`SCSS_CLKOUT_DIV / 2 - 1));

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			sys_r <= 1'b0;
			sys_d_r <= 1'b0;
			div_r <= 2'h0;
			osc2_r <= 1'b0;
			osc2_oe_r <= 1'b0;
			osc1_gpio_r <= 1'b0;
		end else begin
			sys_r <= sys_nxt;
			sys_d_r <= sys_r;
			if (div_tog)
				div_r <= 2'h0;
			else if (sys_rise)
				div_r <= div_r + 2'h1;
			if (div_tog)
				osc2_r <= ~osc2_r;
			osc2_oe_r <= CLKOUT_EN_IN | GPIO_OSC2_OE_IN;
			if (!CLKOUT_EN_IN)
				osc2_r <= GPIO_OSC2_OUT_IN;
			osc1_gpio_r <= use_int & cfg_taken_r;
		end
	end

	assign SYS_CLK_SEL_OUT = sys_r;
	assign SRC_OUT = cur_r;
	assign SWITCHING_OUT = switching_r;
	assign OSC1_GPIO_OUT = osc1_gpio_r;
	assign OSC2_OUT = osc2_r;
	assign OSC2_OE_OUT = osc2_oe_r;

	// ****************************************
	// Checks
	// ****************************************
	property p_switch_low;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(sw_r != SCSS_SW_RUN) |=> !sys_r;
	endproperty
	a_switch_low: assert property (p_switch_low) else $error("clock high during switch");

	property p_pin_release;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(use_int & cfg_taken_r) |=> OSC1_GPIO_OUT;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("input pin not released");

	property p_gpio_pass;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		!CLKOUT_EN_IN |=> (OSC2_OUT == $past(GPIO_OSC2_OUT_IN));
	endproperty
	a_gpio_pass: assert property (p_gpio_pass) else $error("output pin not I/O");

	property p_cfg_hold;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		cfg_taken_r |=> $stable(fosc_r);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config source changed");

	property p_settle;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		!settle_r |=> !SWITCHING_OUT;
	endproperty
	a_settle: assert property (p_settle) else $error("switch before selects settled");

	property p_clkout_oe;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		CLKOUT_EN_IN |=> OSC2_OE_OUT;
	endproperty
	a_clkout_oe: assert property (p_clkout_oe) else $error("clock output not driven");

	property p_rc_pin;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(settle_r & cfg_is_rc & (scs_r == `SCSS_SCS_CFG)) |=> !OSC1_GPIO_OUT;
	endproperty
	a_rc_pin: assert property (p_rc_pin) else $error("input pin freed in RC mode");

	// ****************************************
	// Switch step checks
	// ****************************************
	sequence s_start;
		(sw_r == SCSS_SW_RUN) && settle_r && (want_src != cur_r);
	endsequence

	sequence s_old_low;
		(sw_r == SCSS_SW_OLD_LOW) && !cur_lvl;
	endsequence

	sequence s_new_low;
		(sw_r == SCSS_SW_NEW_LOW) && !new_lvl;
	endsequence

	property p_switch_start;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		s_start |=> SWITCHING_OUT && (nxt_r == $past(want_src));
	endproperty
	a_switch_start: assert property (p_switch_start) else $error("switch not started");

	property p_old_to_new;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		s_old_low |=> (sw_r == SCSS_SW_NEW_LOW) && !sys_r;
	endproperty
	a_old_to_new: assert property (p_old_to_new) else $error("old low step missed");

	property p_src_update;
		@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		s_new_low |=> (SRC_OUT == $past(nxt_r)) && !SWITCHING_OUT;
	endproperty
	a_src_update: assert property (p_src_update) else $error("new source not taken");
endmodule
`default_nettype wire

// [verification/scss_top_tb.sv]
// Self-checking testbench for the system clock source select block
`timescale 1ns/10ps
`default_nettype none
module scss_top_tb;
	import scss_pkg::*;
	logic SYS_CLK_IN = 1'b0, RSTN_IN = 1'b0, CLKOUT_EN_IN = 1'b0, EXT_CLK_IN = 1'b0;
	logic [2:0] FOSC_CFG_IN = 3'h4;
	logic [1:0] SCS_IN = 2'h0, IRCF_IN = 2'h2;
	logic [5:0] TUNE_IN = 6'h00;
	logic GPIO_OSC2_OUT_IN = 1'b0, GPIO_OSC2_OE_IN = 1'b0;
	logic SYS_CLK_SEL_OUT, SWITCHING_OUT, OSC1_GPIO_OUT, OSC2_OUT, OSC2_OE_OUT;
	scss_src_t SRC_OUT;
	int errors = 0, checks = 0, glitches = 0, n, ext_cnt = 0;
	scss_src_t exp_q[$];
	logic prev_sw = 1'b0, prev_clk = 1'b0;
	scss_top dut_u (.SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN), .FOSC_CFG_IN(FOSC_CFG_IN),
		.CLKOUT_EN_IN(CLKOUT_EN_IN), .SCS_IN(SCS_IN), .IRCF_IN(IRCF_IN), .TUNE_IN(TUNE_IN),
		.EXT_CLK_IN(EXT_CLK_IN), .GPIO_OSC2_OUT_IN(GPIO_OSC2_OUT_IN), .GPIO_OSC2_OE_IN(GPIO_OSC2_OE_IN),
		.SYS_CLK_SEL_OUT(SYS_CLK_SEL_OUT), .SRC_OUT(SRC_OUT), .SWITCHING_OUT(SWITCHING_OUT),
		.OSC1_GPIO_OUT(OSC1_GPIO_OUT), .OSC2_OUT(OSC2_OUT), .OSC2_OE_OUT(OSC2_OE_OUT));
	always #4 SYS_CLK_IN = ~SYS_CLK_IN;
	// ****************
	// Compare tasks
	// ****************
	task automatic cmp_src(input scss_src_t act, input scss_src_t exp);
		checks++;
		if (act !== exp) begin
			errors++;
			$display("[FAIL] t=%0t src act=%h exp=%h", $time, act, exp);
		end
	endtask
	task automatic cmp_bit(input logic act, input logic exp);
		checks++;
		if (act !== exp) begin
			errors++;
			$display("[FAIL] t=%0t bit act=%h exp=%h", $time, act, exp);
		end
	endtask
	task automatic cmp_rng(input int act, input int lo, input int hi, input bit inside_ok);
		checks++;
		if (((act >= lo) && (act <= hi)) != inside_ok) begin
			errors++;
			$display("[FAIL] t=%0t count act=%h range=%h..%h", $time, act, lo, hi);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****************
	// Output watchers
	// ****************
	// Switch completion pops the oldest expected source
	always @(negedge SYS_CLK_IN) begin
		if (prev_sw && SWITCHING_OUT === 1'b0 && RSTN_IN) begin
			if (exp_q.size() == 0) begin
				cmp_bit(1'b1, 1'b0);
			end else begin
				cmp_src(SRC_OUT, exp_q.pop_front());
			end
		end
		// Any new rising edge while a switch holds is a glitch
		if (prev_sw && SWITCHING_OUT === 1'b1 && SYS_CLK_SEL_OUT === 1'b1 && !prev_clk) begin
			glitches++;
		end
		prev_sw <= SWITCHING_OUT === 1'b1;
		prev_clk <= SYS_CLK_SEL_OUT === 1'b1;
	end
	// External pin clock, slow enough to be seen through the synchroniser
	always @(negedge SYS_CLK_IN) begin
		ext_cnt <= (ext_cnt == 4) ? 0 : ext_cnt + 1;
		if (ext_cnt == 4) begin
			EXT_CLK_IN <= ~EXT_CLK_IN;
		end
	end
	initial begin
		#(95000 * 8);
		errors++;
		report_and_stop();
	end
	// ****************
	// Stimulus tasks
	// ****************
	task automatic do_reset(input logic [2:0] fosc);
		RSTN_IN = 1'b0;
		FOSC_CFG_IN = fosc;
		exp_q.delete();
		repeat (3) @(negedge SYS_CLK_IN);
		cmp_src(SRC_OUT, SCSS_SRC_EXT);
		cmp_bit(SWITCHING_OUT, 1'b0);
		cmp_bit(OSC2_OE_OUT, 1'b0);
		RSTN_IN = 1'b1;
	endtask
	task automatic wait_done;
		for (int i = 0; i < 15000 && exp_q.size() != 0; i++) begin
			@(negedge SYS_CLK_IN);
		end
		cmp_bit(exp_q.size() == 0, 1'b1);
		repeat (4) @(negedge SYS_CLK_IN);
	endtask
	task automatic count_rises(input int win, output int cnt);
		logic last;
		cnt = 0;
		last = SYS_CLK_SEL_OUT;
		repeat (win) begin
			@(negedge SYS_CLK_IN);
			if (SYS_CLK_SEL_OUT === 1'b1 && last === 1'b0) begin
				cnt++;
			end
			last = SYS_CLK_SEL_OUT;
		end
	endtask
	task automatic step(input logic [1:0] scs, input logic [1:0] ircf, input scss_src_t exp,
			input int win, input int lo, input int hi);
		exp_q.push_back(exp);
		SCS_IN = scs;
		IRCF_IN = ircf;
		wait_done();
		cmp_bit(OSC1_GPIO_OUT, exp != SCSS_SRC_EXT);
		if (win > 0) begin
			count_rises(win, n);
			cmp_rng(n, lo, hi, 1'b1);
		end
	endtask
	task automatic check_clkout;
		int chg, sr;
		logic last, lsys;
		CLKOUT_EN_IN = 1'b1;
		repeat (3) @(negedge SYS_CLK_IN);
		chg = 0;
		sr = 0;
		last = OSC2_OUT;
		lsys = SYS_CLK_SEL_OUT;
		// Quarter rate of the selected clock: one pin change per two rises
		repeat (400) begin
			@(negedge SYS_CLK_IN);
			chg += (OSC2_OUT !== last);
			sr += (SYS_CLK_SEL_OUT === 1'b1 && lsys === 1'b0);
			last = OSC2_OUT;
			lsys = SYS_CLK_SEL_OUT;
		end
		cmp_rng(sr, 20, 400, 1'b1);
		cmp_rng(chg, sr / 2 - 1, sr / 2 + 1, 1'b1);
		cmp_bit(OSC2_OE_OUT, 1'b1);
		CLKOUT_EN_IN = 1'b0;
		repeat (2) begin
			GPIO_OSC2_OUT_IN = $urandom;
			GPIO_OSC2_OE_IN = $urandom;
			repeat (3) @(negedge SYS_CLK_IN);
			cmp_bit(OSC2_OUT, GPIO_OSC2_OUT_IN);
			cmp_bit(OSC2_OE_OUT, GPIO_OSC2_OE_IN);
		end
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		void'($urandom(32'h4ebc));
		// Internal oscillator by configuration, high source picked
		exp_q.push_back(SCSS_SRC_HF);
		do_reset(3'h4);
		exp_q.push_back(SCSS_SRC_HF);
		wait_done();
		cmp_bit(OSC1_GPIO_OUT, 1'b1);
		check_clkout();
		step(2'h1, 2'h2, SCSS_SRC_EXT, 0, 0, 0);
		step(2'h2, 2'h1, SCSS_SRC_MF, 2500, 9, 11);
		// Trim the mid source away from its nominal rate
		TUNE_IN = 6'h18 + 6'($urandom_range(7));
		repeat (200) @(negedge SYS_CLK_IN);
		count_rises(5000, n);
		cmp_rng(n, 18, 22, 1'b0);
		TUNE_IN = 6'h00;
		step(2'h3, 2'h0, SCSS_SRC_LF, 9000, 1, 3);
		step(2'h2, 2'h2, SCSS_SRC_HF, 1000, 120, 136);
		step(2'h0, 2'h1, SCSS_SRC_MF, 0, 0, 0);
		cmp_rng(glitches, 0, 0, 1'b1);
		// Mid-run reset into external RC mode
		SCS_IN = 2'h0;
		do_reset(3'h3);
		repeat (20) @(negedge SYS_CLK_IN);
		cmp_src(SRC_OUT, SCSS_SRC_EXT);
		cmp_bit(OSC1_GPIO_OUT, 1'b0);
		check_clkout();
		report_and_stop();
	end
endmodule
`default_nettype wire
